// ==== usb_power_pkg.sv ====
// Package for the USB function address and power control block.
// Assumes an AXI4-Lite register bus with 32-bit data and byte addresses.
package usb_power_pkg;

  // Printed offsets are register indexes; byte address is four times the index.
  localparam logic [3:0] idx_function_address = 4'h0;
  localparam logic [3:0] idx_power_control = 4'h1;
  localparam logic [3:0] idx_common_irq_flags = 4'h6;
  localparam logic [3:0] idx_irq_enable = 4'h7;
  localparam logic [3:0] idx_link_status = 4'h8;
  localparam logic [5:0] addr_width = 6'h06;

  // Power control field positions, and the function address update bit.
  localparam int pwr_suspend_detect_enable = 0;
  localparam int pwr_suspend_state = 1;
  localparam int pwr_force_resume = 2;
  localparam int pwr_bus_reset_flag = 3;
  localparam int pwr_link_inhibit = 4;
  localparam int pwr_iso_sof_gating_bit = 7;
  localparam int fa_update = 7;

  // Common interrupt flag positions.
  localparam int irq_suspend = 0;
  localparam int irq_resume = 1;
  localparam int irq_reset = 2;
  localparam int irq_sof = 3;

  localparam logic [7:0] function_address_reset = 8'h00;
  localparam logic [7:0] power_control_reset = 8'h10;
  localparam logic [3:0] irq_enable_reset = 4'h6;
  localparam logic [3:0] irq_enable_after_bus_reset = 4'he;

  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum logic [1:0] {
    link_active = 2'h0,
    link_suspended = 2'h1,
    link_waking = 2'h2
  } link_state_t;

  // Events coming from the serial interface engine.
  typedef struct packed {
    logic bus_reset;
    logic suspend;
    logic resume;
    logic sof;
    logic transfer_done;
    logic in_token_iso;
  } link_events_t;

  typedef struct packed {
    logic [6:0] active_address;
    logic [6:0] pending_address;
    logic address_update;
    logic iso_sof_gating_bit;
    logic link_inhibit;
    logic bus_reset_flag;
    logic force_resume;
    logic suspend_detect_enable;
    link_state_t link_state;
    logic resume_seen;
    logic [3:0] common_irq_flags;
    logic [3:0] irq_enable;
    logic iso_released;
    logic send_zero_length;
    logic endpoint_clear;
    logic aw_done;
    logic w_done;
    logic [3:0] aw_index;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ctrl_state_t;

endpackage : usb_power_pkg

// ==== usb_function_address_power_ctrl.sv ====
// Device-level USB function address, reset, suspend, resume and inhibit control.
// Assumes a serial interface engine supplies one-cycle event pulses and a level
// for reset signaling, and that inputs are synchronous to aclk.
//
// Operation
// RL1 - Address write sets the update bit; cleared once new address applies.
// RL2 - Seven-bit address; new value matches only after current request completes.
// RL3 - Old address stays in use until the current transfer ends.
// RL4 - Firmware writes the host-assigned address on set-address request.
// RL5 - Bus reset flag reads one while reset signaling is present.
// RL6 - Bus reset clears the address and flushes endpoint FIFOs.
// RL7 - Bus reset clears endpoint control/status and index registers.
// RL8 - Bus reset enables all interrupts but suspend, clears flags, raises reset.
// RL9 - Writing one to bus reset bit resets all USB registers.
// RL10 - Suspend detection enabled enters suspend on signaling; else ignored.
// RL11 - Suspend-state bit is set on entering suspend.
// RL12 - Suspend exits on resume, bus reset, or device or USB reset.
// RL13 - Detected host resume raises resume interrupt if enabled.
// RL14 - Force-resume written one while suspended drives remote wakeup signaling.
// RL15 - Firmware clears force-resume ten to fifteen ms later.
// RL16 - Suspend-state clears on force-resume cleared or flag read after resume; the code clears it on the resume event itself.
// RL17 - Reading an interrupt flag register clears all its flags.
// RL18 - With gating off, ready iso packet goes on the next IN token.
// RL19 - With gating on, iso packets wait for SOF; earlier IN gets zero length.
// RL20 - Inhibit resets to one; while one all USB traffic is ignored.
// RL21 - Inhibit returns to one only through reset; writing one does nothing.
// RL22 - Firmware configures everything before clearing inhibit.
// RL23 - Force-resume written while not suspended makes no resume signaling.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module usb_function_address_power_ctrl
  import usb_power_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire link_events_t link_events,
  input wire logic reset_signaling,
  output logic [6:0] match_address,
  output logic link_enable,
  output logic drive_resume,
  output logic suspended,
  output logic endpoint_clear,
  output logic iso_send_enable,
  output logic iso_zero_length,
  output logic [3:0] irq_enable,
  output logic [3:0] common_irq_flags
);

  ctrl_state_t state;
  ctrl_state_t next_state;
  logic soft_reset;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic write_fire;
  logic [31:0] read_word;

  function automatic logic [7:0] merge_byte(input logic [7:0] old_value,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
    merge_byte = strb[0] ? data[7:0] : old_value;
  endfunction : merge_byte

  // A write channel is taken whenever it has not itself been stored yet, whatever
  // its mate does, and never while a response is still outstanding.
  // Ready never looks at the decoded write, since that would close a loop through it.
  assign s_axi_awready = !state.aw_done && !state.bvalid;
  assign s_axi_wready = !state.w_done && !state.bvalid;
  assign s_axi_arready = !state.rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_comb begin
    logic [3:0] widx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [7:0] wbyte;
    logic [3:0] ridx;
    logic reading_flags;
    widx = aw_take ? s_axi_awaddr[5:2] : state.aw_index;
    wdata = w_take ? s_axi_wdata : state.w_data;
    wstrb = w_take ? s_axi_wstrb : state.w_strb;
    ridx = s_axi_araddr[5:2];
    next_state = state;
    write_fire = (aw_take || state.aw_done) && (w_take || state.w_done);
    soft_reset = 1'b0;
    read_word = 32'h0000_0000;
    wbyte = 8'h00;
    reading_flags = ar_take && (ridx == idx_common_irq_flags);
    next_state.endpoint_clear = 1'b0;
    next_state.send_zero_length = 1'b0;

    // Address channel and data channel are latched independently.
    if (aw_take) begin
      next_state.aw_done = 1'b1;
      next_state.aw_index = s_axi_awaddr[5:2];
    end
    if (w_take) begin
      next_state.w_done = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end

    // RL3 keep old address
    if (state.address_update && link_events.transfer_done) begin
      next_state.active_address = state.pending_address;
      // RL1 update bit clears
      next_state.address_update = 1'b0;
    end

    // RL5 flag follows reset
    next_state.bus_reset_flag = reset_signaling;

    // RL10 suspend entry
    if (state.suspend_detect_enable && link_events.suspend && !state.link_inhibit
        && state.link_state == link_active) begin
      // RL11 suspend state set
      next_state.link_state = link_suspended;
      next_state.common_irq_flags[irq_suspend] = 1'b1;
    end

    // RL12 exit on resume
    if (link_events.resume && state.link_state == link_suspended) begin
      next_state.link_state = link_active;
      next_state.resume_seen = 1'b1;
      // RL13 resume interrupt
      next_state.common_irq_flags[irq_resume] = 1'b1;
    end

    // RL19 release on SOF
    if (link_events.sof && !state.link_inhibit) begin
      next_state.iso_released = 1'b1;
      next_state.common_irq_flags[irq_sof] = 1'b1;
    end
    // RL19 early IN token
    if (link_events.in_token_iso && state.iso_sof_gating_bit && !state.iso_released
        && !state.link_inhibit) begin
      next_state.send_zero_length = 1'b1;
    end
    if (link_events.in_token_iso && state.iso_released) begin
      next_state.iso_released = 1'b0;
    end

    // RL17 read clears flags
    if (reading_flags) begin
      next_state.common_irq_flags = 4'h0;
    end
    // Events raised in the same cycle survive the clearing read.
    if (reading_flags) begin
      if (state.link_state == link_suspended && state.resume_seen == 1'b0) begin
        next_state.common_irq_flags = 4'h0;
      end
      next_state.common_irq_flags[irq_suspend] = state.suspend_detect_enable
          && link_events.suspend && !state.link_inhibit && state.link_state == link_active;
      next_state.common_irq_flags[irq_resume] = link_events.resume
          && state.link_state == link_suspended;
      next_state.common_irq_flags[irq_sof] = link_events.sof && !state.link_inhibit;
      next_state.common_irq_flags[irq_reset] = 1'b0;
      // RL16 read after resume
      if (state.resume_seen) begin
        next_state.resume_seen = 1'b0;
      end
    end

    if (write_fire) begin
      next_state.aw_done = 1'b0;
      next_state.w_done = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = resp_okay;
      wbyte = merge_byte(8'h00, wdata, wstrb);
      case (widx)
        idx_function_address: begin
          if (wstrb[0]) begin
            next_state.pending_address = wbyte[6:0];
            // RL1 update bit sets
            next_state.address_update = 1'b1;
          end
        end
        idx_power_control: begin
          if (wstrb[0]) begin
            next_state.suspend_detect_enable = wbyte[pwr_suspend_detect_enable];
            next_state.iso_sof_gating_bit = wbyte[pwr_iso_sof_gating_bit];
            // RL21 inhibit only clears
            if (!wbyte[pwr_link_inhibit]) begin
              next_state.link_inhibit = 1'b0;
            end
            // RL14 remote wakeup start
            if (wbyte[pwr_force_resume] && state.link_state == link_suspended) begin
              next_state.force_resume = 1'b1;
              next_state.link_state = link_waking;
            end
            // RL23 no wakeup when awake
            if (!wbyte[pwr_force_resume]) begin
              next_state.force_resume = 1'b0;
              // RL16 end of wakeup
              if (state.link_state == link_waking) begin
                next_state.link_state = link_active;
              end
            end
            // RL9 forced USB reset
            soft_reset = wbyte[pwr_bus_reset_flag];
          end
        end
        idx_irq_enable: begin
          if (wstrb[0]) begin
            next_state.irq_enable = wbyte[3:0];
          end
        end
        idx_common_irq_flags, idx_link_status: begin
        end
        default: begin
          next_state.bresp = resp_slverr;
        end
      endcase
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end

    // RL6 bus reset effects
    if (reset_signaling && !state.link_inhibit) begin
      next_state.active_address = 7'h00;
      next_state.pending_address = 7'h00;
      next_state.address_update = 1'b0;
      // RL7 endpoint registers cleared
      // The clear is one pulse at detection, not repeated while signaling lasts.
      next_state.endpoint_clear = !state.bus_reset_flag;
      // RL12 exit on bus reset
      next_state.link_state = link_active;
      next_state.force_resume = 1'b0;
      next_state.resume_seen = 1'b0;
      // RL8 interrupts re-enabled
      next_state.irq_enable = irq_enable_after_bus_reset;
      if (!state.bus_reset_flag) begin
        next_state.common_irq_flags = 4'h0;
        next_state.common_irq_flags[irq_reset] = irq_enable_after_bus_reset[irq_reset];
      end
    end

    if (ar_take) begin
      next_state.rvalid = 1'b1;
      next_state.rresp = resp_okay;
      case (ridx)
        idx_function_address: begin
          read_word[7:0] = {state.address_update, state.pending_address};
        end
        idx_power_control: begin
          read_word[pwr_iso_sof_gating_bit] = state.iso_sof_gating_bit;
          read_word[pwr_link_inhibit] = state.link_inhibit;
          read_word[pwr_bus_reset_flag] = state.bus_reset_flag;
          read_word[pwr_force_resume] = state.force_resume;
          read_word[pwr_suspend_state] = state.link_state != link_active;
          read_word[pwr_suspend_detect_enable] = state.suspend_detect_enable;
        end
        idx_common_irq_flags: begin
          read_word[3:0] = state.common_irq_flags;
        end
        idx_irq_enable: begin
          read_word[3:0] = state.irq_enable;
        end
        idx_link_status: begin
          read_word[7:0] = {1'b0, state.active_address};
        end
        default: begin
          next_state.rresp = resp_slverr;
        end
      endcase
      next_state.rdata = read_word;
    end else if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end

    // RL9 registers to defaults
    if (soft_reset) begin
      next_state.active_address = 7'h00;
      next_state.pending_address = function_address_reset[6:0];
      next_state.address_update = function_address_reset[fa_update];
      next_state.iso_sof_gating_bit = power_control_reset[pwr_iso_sof_gating_bit];
      // RL21 inhibit set by reset
      next_state.link_inhibit = power_control_reset[pwr_link_inhibit];
      next_state.force_resume = 1'b0;
      next_state.suspend_detect_enable = power_control_reset[pwr_suspend_detect_enable];
      next_state.link_state = link_active;
      next_state.resume_seen = 1'b0;
      next_state.common_irq_flags = 4'h0;
      next_state.irq_enable = irq_enable_reset;
      next_state.iso_released = 1'b0;
      next_state.endpoint_clear = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
      state.pending_address <= function_address_reset[6:0];
      // RL20 inhibit after power-on
      state.link_inhibit <= power_control_reset[pwr_link_inhibit];
      state.irq_enable <= irq_enable_reset;
      state.link_state <= link_active;
    end else begin
      state <= next_state;
    end
  end

  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rresp = state.rresp;
  assign s_axi_rdata = state.rdata;
  // RL2 matching address
  assign match_address = state.active_address;
  // RL20 traffic ignored
  assign link_enable = !state.link_inhibit;
  assign drive_resume = state.force_resume;
  assign suspended = state.link_state != link_active;
  assign endpoint_clear = state.endpoint_clear;
  // RL18 iso send gate
  assign iso_send_enable = !state.link_inhibit
      && (!state.iso_sof_gating_bit || state.iso_released);
  assign iso_zero_length = state.send_zero_length;
  assign irq_enable = state.irq_enable;
  assign common_irq_flags = state.common_irq_flags;

endmodule : usb_function_address_power_ctrl

// ==== usb_function_address_power_ctrl_asserts.sv ====
// Checker for the address and power control block, bound from the bench.
// Assumes link event pulses and reset signaling are synchronous to aclk.
`timescale 1ns/1ps
module usb_function_address_power_ctrl_asserts
  import usb_power_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire link_events_t link_events,
  input wire logic reset_signaling,
  input wire logic [6:0] match_address,
  input wire logic link_enable,
  input wire logic drive_resume,
  input wire logic suspended,
  input wire logic endpoint_clear,
  input wire logic iso_zero_length,
  input wire logic [3:0] irq_enable,
  input wire logic [3:0] common_irq_flags
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_bus_rst;
    $rose(reset_signaling) && link_enable;
  endsequence
  sequence s_host_resume;
    link_events.resume && suspended;
  endsequence
  property p_rst_addr;
    s_bus_rst |-> ##[1:2] (match_address == 7'h00);
  endproperty
  a_rst_addr: assert property (p_rst_addr) else $error("address kept");
  property p_rst_irq_en;
    s_bus_rst |-> ##[1:2] (irq_enable == irq_enable_after_bus_reset);
  endproperty
  a_rst_irq_en: assert property (p_rst_irq_en) else $error("enables wrong");
  property p_rst_flush;
    s_bus_rst |-> ##[1:2] endpoint_clear;
  endproperty
  a_rst_flush: assert property (p_rst_flush) else $error("no flush");
  property p_susp_entry;
    $rose(suspended) |-> $past(link_events.suspend)
      && (!irq_enable[irq_suspend] || common_irq_flags[irq_suspend]);
  endproperty
  a_susp_entry: assert property (p_susp_entry) else $error("bad suspend");
  property p_resume_exit;
    s_host_resume |-> ##[1:2] !suspended;
  endproperty
  a_resume_exit: assert property (p_resume_exit) else $error("still suspended");
  property p_resume_irq;
    s_host_resume and irq_enable[irq_resume] |-> ##[1:2] common_irq_flags[irq_resume];
  endproperty
  a_resume_irq: assert property (p_resume_irq) else $error("no resume flag");
  property p_wake_cause;
    $rose(drive_resume) |-> $past(suspended);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake unsuspended");
  property p_inhibit;
    !link_enable && !suspended |=> !suspended;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit ignored");
  property p_zero_len;
    iso_zero_length |-> $past(link_events.in_token_iso);
  endproperty
  a_zero_len: assert property (p_zero_len) else $error("stray zero length");
endmodule : usb_function_address_power_ctrl_asserts

// ==== usb_host_model.sv ====
// Host-side model that drives bus events into the block.
// Assumes its tasks are called just after a rising edge of aclk.
`timescale 1ns/1ps
module usb_host_model
  import usb_power_pkg::*;
(
  input wire logic aclk,
  output link_events_t link_events,
  output logic reset_signaling
);
  initial begin
    link_events = '0;
    reset_signaling = 1'b0;
  end
  // Events are single-cycle; a gap cycle keeps two events apart.
  task ev(input int i);
    link_events[i] <= 1'b1;
    @(posedge aclk);
    link_events <= '0;
    @(posedge aclk);
  endtask : ev
  task bus_rst(input logic v);
    reset_signaling <= v;
    @(posedge aclk);
  endtask : bus_rst
endmodule : usb_host_model

// ==== usb_function_address_power_ctrl_tb.sv ====
// Self-checking bench for the address and power control block.
// Assumes the host model and the checker files are compiled first.
`timescale 1ns/1ps
module usb_function_address_power_ctrl_tb
  import usb_power_pkg::*;
;
  localparam int e_susp = 4, e_res = 3, e_sof = 2, e_done = 1, e_iso = 0;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata;
  wire logic awready, wready, bvalid, arready, rvalid, reset_signaling, link_enable;
  wire logic drive_resume, suspended, endpoint_clear, iso_send_enable, iso_zero_length;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [6:0] match_address;
  wire logic [3:0] irq_enable, common_irq_flags;
  link_events_t link_events;
  int n_mismatch, n_compared, n_epc, n_zl;
  usb_host_model i_usb_host_model (.aclk, .link_events, .reset_signaling);
  usb_function_address_power_ctrl i_usb_function_address_power_ctrl (.aclk, .aresetn,
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_events, .reset_signaling, .match_address, .link_enable, .drive_resume,
    .suspended, .endpoint_clear, .iso_send_enable, .iso_zero_length, .irq_enable,
    .common_irq_flags);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Pulse outputs are counted here so a scenario cannot miss a one-cycle flag.
  always @(posedge aclk) begin
    if (endpoint_clear === 1'b1) n_epc <= n_epc + 1;
    if (iso_zero_length === 1'b1) n_zl <= n_zl + 1;
  end
  task finish_test();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task ck(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : ck
  task wr(input logic [5:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    ck(bresp, resp_okay);
    @(posedge aclk);
  endtask : wr
  task rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r = resp_okay);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    ck(rdata, e);
    ck(rresp, r);
    @(posedge aclk);
  endtask : rd
  task t_regs();
    rd(6'h04, 32'h10);
    rd(6'h00, 32'h0);
    rd(6'h1c, 32'h6);
    rd(6'h3c, 32'h0, resp_slverr);
  endtask : t_regs
  task t_addr();
    wr(6'h04, 32'h18);
    ck(n_epc, 1);
    ck(link_enable, 0);
    wr(6'h04, 32'h0);
    ck(link_enable, 1);
    wr(6'h00, 32'h25);
    rd(6'h00, 32'ha5);
    ck(match_address, 0);
    rd(6'h20, 32'h0);
    i_usb_host_model.ev(e_done);
    rd(6'h00, 32'h25);
    ck(match_address, 7'h25);
    rd(6'h20, 32'h25);
    wr(6'h04, 32'h10);
    rd(6'h04, 32'h0);
  endtask : t_addr
  task t_susp();
    i_usb_host_model.ev(e_susp);
    ck(suspended, 0);
    wr(6'h1c, 32'hf);
    wr(6'h04, 32'h1);
    i_usb_host_model.ev(e_susp);
    rd(6'h04, 32'h3);
    rd(6'h18, 32'h1);
    ck(common_irq_flags, 0);
    wr(6'h04, 32'h5);
    ck(drive_resume, 1);
    // The wake period is kept short; the block holds no timer of its own.
    wr(6'h04, 32'h1);
    ck(drive_resume, 0);
    ck(suspended, 0);
    rd(6'h18, 32'h0);
  endtask : t_susp
  task t_resume();
    i_usb_host_model.ev(e_susp);
    ck(suspended, 1);
    i_usb_host_model.ev(e_res);
    ck(suspended, 0);
    ck(common_irq_flags, 4'h3);
    rd(6'h18, 32'h3);
    ck(common_irq_flags, 0);
    wr(6'h04, 32'h5);
    ck(drive_resume, 0);
    wr(6'h04, 32'h1);
  endtask : t_resume
  task t_iso();
    wr(6'h04, 32'h81);
    i_usb_host_model.ev(e_iso);
    @(posedge aclk);
    ck(n_zl, 1);
    ck(iso_send_enable, 0);
    i_usb_host_model.ev(e_sof);
    ck(iso_send_enable, 1);
    wr(6'h04, 32'h1);
    i_usb_host_model.ev(e_iso);
    @(posedge aclk);
    ck(iso_send_enable, 1);
    ck(n_zl, 1);
  endtask : t_iso
  task t_bus_rst();
    wr(6'h00, 32'h11);
    i_usb_host_model.ev(e_done);
    i_usb_host_model.ev(e_susp);
    wr(6'h1c, 32'h1);
    i_usb_host_model.bus_rst(1'b1);
    repeat (2) @(posedge aclk);
    ck(match_address, 0);
    ck(irq_enable, irq_enable_after_bus_reset);
    ck(suspended, 0);
    ck(common_irq_flags, 4'h4);
    ck(n_epc, 2);
    rd(6'h04, 32'h9);
    i_usb_host_model.bus_rst(1'b0);
    @(posedge aclk);
    rd(6'h04, 32'h1);
  endtask : t_bus_rst
  task t_sw_rst();
    wr(6'h00, 32'h33);
    wr(6'h04, 32'h8);
    rd(6'h04, 32'h10);
    rd(6'h00, 32'h0);
    rd(6'h1c, 32'h6);
    ck(n_epc, 3);
    ck(link_enable, 0);
  endtask : t_sw_rst
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_addr();
    t_susp();
    t_resume();
    t_iso();
    t_bus_rst();
    t_sw_rst();
    finish_test();
  end
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
endmodule : usb_function_address_power_ctrl_tb
bind usb_function_address_power_ctrl usb_function_address_power_ctrl_asserts
  i_usb_function_address_power_ctrl_asserts (.aclk, .aresetn, .link_events,
  .reset_signaling, .match_address, .link_enable, .drive_resume, .suspended,
  .endpoint_clear, .iso_zero_length, .irq_enable, .common_irq_flags);
